// ==== hw/seec_pkg.sv ====
// shared constants and state encodings for the serial memory boot block
package seec_pkg;

  // ****************************************
  // serial timing
  // ****************************************
  localparam int unsigned SCK_HZ = 7_800_000;
  localparam int unsigned SCK_DIV = 4;
  localparam int unsigned LINK_HZ = SCK_HZ * SCK_DIV;
  localparam int unsigned DESEL_NS = 100;
  localparam int unsigned DESEL_RAW =
    (DESEL_NS * (LINK_HZ / 1000) + 999_999) / 1_000_000;
  localparam logic [2:0] DESEL_CYC =
    3'((DESEL_RAW < 1) ? 1 : DESEL_RAW);
  localparam logic [1:0] PH_LAST = 2'(SCK_DIV - 1);

  // ****************************************
  // frame layout
  // ****************************************
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [6:0] CMD_BITS = 7'h18;
  localparam int RX_W = 48;

  // ****************************************
  // memory map
  // ****************************************
  localparam logic [15:0] IMG_BASE = 16'h0000;
  localparam logic [15:0] ROM_BASE = 16'h8000;
  localparam logic [15:0] HDR_BYTES = 16'h0002;
  localparam logic [15:0] REC_BYTES = 16'h0006;
  localparam logic [15:0] REC_MAX =
    16'((ROM_BASE - IMG_BASE - HDR_BYTES) / REC_BYTES);
  localparam logic [15:0] BLANK_CNT = 16'hFFFF;
  localparam logic [2:0] LEN_HDR = 3'h2;
  localparam logic [2:0] LEN_REC = 3'h6;
  localparam logic [2:0] LEN_ROM = 3'h4;
  localparam logic [3:0] RST_HOLD = 4'hF;

  // ****************************************
  // state encodings
  // ****************************************
  typedef enum logic [2:0] {
    CS_BOOT = 3'h0,
    CS_HDR = 3'h1,
    CS_REC = 3'h3,
    CS_READY = 3'h2,
    CS_ROM = 3'h6
  } seec_core_st_t;

  typedef enum logic [1:0] {
    LS_IDLE = 2'h0,
    LS_CMD = 2'h1,
    LS_RX = 2'h3,
    LS_GAP = 2'h2
  } seec_link_st_t;

endpackage

// ==== hw/seec_sync.sv ====
// two-stage synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module seec_sync (
  // destination clock
  input wire logic i_clk,
  // asynchronous level in, synchronised level out
  input wire logic i_d,
  output logic o_q
);
  typedef struct packed {
    logic meta;
    logic hold;
  } seec_sync_t;

  seec_sync_t q;
  seec_sync_t d;

  // no reset: it must pass a reset request through itself
  always_comb begin
    d.meta = i_d;
    d.hold = q.meta;
  end

  always_ff @(posedge i_clk) begin
    q <= d;
  end

  assign o_q = q.hold;
endmodule
`default_nettype wire

// ==== hw/seec_spi_eng.sv ====
// serial memory read engine on the link clock
`timescale 1ns/1ps
`default_nettype none
module seec_spi_eng import seec_pkg::*; (
  // link clock and reset
  input wire logic i_lclk,
  input wire logic i_lrst,
  // request from the core domain, held while pending
  input wire logic i_req_tgl,
  input wire logic [15:0] i_addr,
  input wire logic [2:0] i_len,
  // answer to the core domain
  output logic o_ack_tgl,
  output logic [RX_W-1:0] o_data,
  // memory pins
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  typedef struct packed {
    seec_link_st_t st;
    logic [1:0] ph;
    logic [6:0] nb;
    logic [2:0] gap;
    logic [23:0] tx;
    logic [RX_W-1:0] rx;
    logic req_seen;
    logic ack;
    logic sck;
    logic cs_n;
    logic mosi;
  } seec_eng_t;

  localparam seec_eng_t ENG_RST = '{st: LS_IDLE, cs_n: 1'b1, default: '0};

  seec_eng_t q;
  seec_eng_t d;
  logic req_s;
  logic miso_s;

  seec_sync u_req (.i_clk(i_lclk), .i_d(i_req_tgl), .o_q(req_s));
  seec_sync u_miso (.i_clk(i_lclk), .i_d(i_miso), .o_q(miso_s));

  always_comb begin
    d = q;
    case (q.st)
      LS_IDLE: begin
        if (req_s != q.req_seen) begin
          d.req_seen = req_s;
          d.st = LS_CMD;
          d.cs_n = 1'b0;
          d.tx = {OP_READ, i_addr};
          d.mosi = OP_READ[7];
          d.ph = 2'h0;
          d.nb = CMD_BITS;
          d.rx = '0;
        end
      end
      LS_CMD, LS_RX: begin
        d.ph = q.ph + 2'h1;
        // one serial clock per SCK_DIV link cycles
        d.sck = d.ph[1];
        if (q.ph == PH_LAST) begin
          d.nb = q.nb - 7'h01;
          if (q.st == LS_CMD) begin
            d.tx = {q.tx[22:0], 1'b0};
            d.mosi = q.tx[22];
          end else begin
            d.rx = {q.rx[RX_W-2:0], miso_s};
          end
          if (q.nb == 7'h01) begin
            if (q.st == LS_CMD) begin
              d.st = LS_RX;
              d.mosi = 1'b0;
              d.nb = {1'b0, i_len, 3'b000};
            end else begin
              d.st = LS_GAP;
              d.cs_n = 1'b1;
              d.gap = DESEL_CYC;
              d.ack = ~q.ack;
            end
          end
        end
      end
      LS_GAP: begin
        d.gap = q.gap - 3'h1;
        if (q.gap == 3'h1) begin
          d.st = LS_IDLE;
        end
      end
      default: begin
        d = ENG_RST;
      end
    endcase
  end

  always_ff @(posedge i_lclk) begin
    if (i_lrst) begin
      q <= ENG_RST;
    end else begin
      q <= d;
    end
  end

  assign o_ack_tgl = q.ack;
  assign o_data = q.rx;
  assign o_sck = q.sck;
  assign o_cs_n = q.cs_n;
  assign o_mosi = q.mosi;
endmodule
`default_nettype wire

// ==== hw/seec_top.sv ====
// serial memory boot controller: image load and expansion rom reads
`timescale 1ns/1ps
`default_nettype none
module seec_top import seec_pkg::*; (
  // core clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_fundamental_reset_n,
  // serial engine clock
  input wire logic i_link_clk,
  // serial memory pins
  output logic o_mem_serial_clock,
  output logic o_mem_select_n,
  output logic o_mem_serial_in,
  input wire logic i_mem_serial_out_pin,
  // register image writes
  output logic o_cfg_we,
  output logic [15:0] o_cfg_index,
  output logic [31:0] o_cfg_data,
  output logic o_load_done,
  output logic o_load_err,
  // expansion rom reads
  input wire logic i_rom_req,
  input wire logic [14:0] i_rom_addr,
  output logic o_rom_busy,
  output logic o_rom_valid,
  output logic [31:0] o_rom_data
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    seec_core_st_t st;
    logic rst;
    logic [3:0] rcnt;
    logic req;
    logic ack_seen;
    logic [15:0] addr;
    logic [2:0] len;
    logic [15:0] cnt;
    logic [15:0] idx;
    logic cfg_we;
    logic [15:0] cfg_index;
    logic [31:0] cfg_data;
    logic done;
    logic err;
    logic busy;
    logic rom_valid;
    logic [31:0] rom_data;
  } seec_core_t;

  localparam seec_core_t CORE_RST = '{
    st: CS_BOOT,
    rst: 1'b1,
    busy: 1'b1,
    default: '0
  };

  seec_core_t q;
  seec_core_t d;
  logic frst_s;
  logic ack_s;
  logic ack_ev;
  logic lrst;
  logic eng_ack;
  logic [RX_W-1:0] rx;
  logic [15:0] next_idx;

  // byte address of image record i
  function automatic logic [15:0] rec_addr(input logic [15:0] i);
    rec_addr = 16'(IMG_BASE + HDR_BYTES + 16'(i * REC_BYTES));
  endfunction

  // ****************************************
  // crossings
  // ****************************************
  seec_sync u_frst (
    .i_clk(i_clk),
    .i_d(i_fundamental_reset_n),
    .o_q(frst_s)
  );

  seec_sync u_ack (
    .i_clk(i_clk),
    .i_d(eng_ack),
    .o_q(ack_s)
  );

  // link side reset follows the stretched core reset
  seec_sync u_lrst (
    .i_clk(i_link_clk),
    .i_d(q.rst),
    .o_q(lrst)
  );

  // addr and len stay put from request toggle until the ack returns
  seec_spi_eng u_eng (
    .i_lclk(i_link_clk),
    .i_lrst(lrst),
    .i_req_tgl(q.req),
    .i_addr(q.addr),
    .i_len(q.len),
    .o_ack_tgl(eng_ack),
    .o_data(rx),
    .o_sck(o_mem_serial_clock),
    .o_cs_n(o_mem_select_n),
    .o_mosi(o_mem_serial_in),
    .i_miso(i_mem_serial_out_pin)
  );

  // ****************************************
  // loader and rom port
  // ****************************************
  always_comb begin
    d = q;
    d.cfg_we = 1'b0;
    d.rom_valid = 1'b0;
    d.ack_seen = ack_s;
    ack_ev = ack_s ^ q.ack_seen;
    next_idx = q.idx + 16'h0001;
    if (q.rst || !frst_s) begin
      // held long enough for the slow link side to see it
      d = CORE_RST;
      d.ack_seen = ack_s;
      d.req = q.rst ? q.req : 1'b0;
      d.rcnt = frst_s ? q.rcnt + 4'h1 : 4'h0;
      d.rst = !(frst_s && q.rst && q.rcnt == RST_HOLD);
      if (!q.rst) begin
        d.req = 1'b0;
      end
    end else begin
      case (q.st)
        CS_BOOT: begin
          d.addr = IMG_BASE;
          d.len = LEN_HDR;
          d.req = ~q.req;
          d.st = CS_HDR;
        end
        CS_HDR: begin
          if (ack_ev) begin
            d.cnt = rx[15:0];
            d.idx = 16'h0000;
            if (rx[15:0] == BLANK_CNT || rx[15:0] == 16'h0000) begin
              // blank or empty memory: keep reset defaults
              d.st = CS_READY;
              d.done = 1'b1;
              d.busy = 1'b0;
            end else if (rx[15:0] > REC_MAX) begin
              // image would spill into the rom half
              d.st = CS_READY;
              d.done = 1'b1;
              d.err = 1'b1;
              d.busy = 1'b0;
            end else begin
              d.addr = rec_addr(16'h0000);
              d.len = LEN_REC;
              d.req = ~q.req;
              d.st = CS_REC;
            end
          end
        end
        CS_REC: begin
          if (ack_ev) begin
            // later register writes may overwrite these
            d.cfg_we = 1'b1;
            d.cfg_index = rx[47:32];
            d.cfg_data = rx[31:0];
            d.idx = next_idx;
            if (next_idx == q.cnt) begin
              d.st = CS_READY;
              d.done = 1'b1;
              d.busy = 1'b0;
            end else begin
              d.addr = rec_addr(next_idx);
              d.req = ~q.req;
            end
          end
        end
        CS_READY: begin
          if (i_rom_req) begin
            d.addr = ROM_BASE | {1'b0, i_rom_addr};
            d.len = LEN_ROM;
            d.req = ~q.req;
            d.busy = 1'b1;
            d.st = CS_ROM;
          end
        end
        CS_ROM: begin
          if (ack_ev) begin
            d.rom_data = rx[31:0];
            d.rom_valid = 1'b1;
            d.busy = 1'b0;
            d.st = CS_READY;
          end
        end
        default: begin
          d = CORE_RST;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign o_cfg_we = q.cfg_we;
  assign o_cfg_index = q.cfg_index;
  assign o_cfg_data = q.cfg_data;
  assign o_load_done = q.done;
  assign o_load_err = q.err;
  assign o_rom_busy = q.busy;
  assign o_rom_valid = q.rom_valid;
  assign o_rom_data = q.rom_data;

  // ****************************************
  // checks
  // ****************************************
  logic hs_q;
  logic [6:0] hc_q;

  // serial clock rising edges within the current frame
  always_ff @(posedge i_link_clk) begin
    if (lrst || o_mem_select_n) begin
      hc_q <= 7'h00;
    end else if (o_mem_serial_clock && !hs_q) begin
      hc_q <= hc_q + 7'h01;
    end
    hs_q <= o_mem_serial_clock;
  end

  a_cfg_lower_half: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_cfg_we |-> $past(q.addr) == rec_addr($past(q.idx))
      && $past(q.addr) < ROM_BASE)
    else $error("image record read outside the lower half");

  a_rom_upper_half: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (q.st == CS_ROM && ack_ev && !q.rst && frst_s)
      |=> o_rom_valid && !o_rom_busy && $past(q.addr[15]))
    else $error("rom answer missing or not from the upper half");

  a_reset_clears: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !frst_s |=> q.rst && !o_cfg_we && !o_load_done && o_rom_busy)
    else $error("fundamental reset did not reset the block");

  a_boot_load: assert property (
    @(posedge i_clk) disable iff (i_rst)
    ($fell(q.rst) && frst_s) |=> q.st == CS_HDR
      && q.addr == IMG_BASE && q.len == LEN_HDR
      && q.req != $past(q.req))
    else $error("image load did not start after reset");

  a_rec_write: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (q.st == CS_REC && ack_ev && !q.rst && frst_s)
      |=> o_cfg_we && o_cfg_data == $past(rx[31:0]))
    else $error("record read did not produce a register write");

  a_sck_rate: assert property (
    @(posedge i_link_clk) disable iff (lrst)
    $rose(o_mem_serial_clock) |=> o_mem_serial_clock
      ##1 !o_mem_serial_clock ##1 !o_mem_serial_clock)
    else $error("serial clock high time is not two link cycles");

  a_sck_in_frame: assert property (
    @(posedge i_link_clk) disable iff (lrst)
    o_mem_serial_clock |-> !o_mem_select_n)
    else $error("serial clock toggled outside a frame");

  a_opcode_first: assert property (
    @(posedge i_link_clk) disable iff (lrst)
    $fell(o_mem_select_n) |-> o_mem_serial_in == OP_READ[7]
      && !o_mem_serial_clock)
    else $error("frame did not open with the read opcode");

  a_frame_bits: assert property (
    @(posedge i_link_clk) disable iff (lrst)
    $rose(o_mem_select_n) |-> hc_q == 7'(CMD_BITS
      + {1'b0, q.len, 3'b000}))
    else $error("frame length is not opcode, 16-bit address, data");

endmodule
`default_nettype wire

// ==== testbench/seec_mem_model.sv ====
// behavioural serial memory answering mode 0 read frames
`timescale 1ns/1ps
`default_nettype none
module seec_mem_model import seec_pkg::*; (
  // serial pins seen from the memory
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so
);
  logic [7:0] mem [0:65535];
  logic [23:0] cmd;
  logic [15:0] ptr;
  logic [7:0] sh;
  logic bad;
  int nbit;
  initial begin
    o_so = 1'b1;
    nbit = 0;
    bad = 1'b0;
    sh = 8'h00;
  end
  // opcode then 16 address bits, msb first
  always @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      nbit = 0;
    end else begin
      cmd = {cmd[22:0], i_si};
      nbit = nbit + 1;
      if (nbit == 24) begin
        ptr = cmd[15:0];
        bad = (cmd[23:16] !== OP_READ);
      end
    end
  end
  // pull-up holds the line high while deselected; a bad opcode garbles data
  always @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_so = 1'b1;
    end else if (nbit >= 24) begin
      if ((nbit - 24) % 8 == 0) begin
        // byte offset from the bit count, so ptr keeps a single writer
        sh = mem[16'(ptr + 16'((nbit - 24) / 8))] ^ {8{bad}};
      end
      o_so = sh[7];
      sh = sh << 1;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/serial_eeprom_controller_tb.sv ====
// self-checking bench: image load, rom reads, resets and serial timing
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_controller_tb;
  import seec_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_fundamental_reset_n = 1'b1;
  logic i_link_clk = 1'b0;
  logic i_rom_req = 1'b0;
  logic [14:0] i_rom_addr = 15'h0000;
  logic sck, cs_n, si, so, cfg_we, load_done, load_err;
  logic rom_busy, rom_valid, sck_prev, have;
  logic [15:0] cfg_index;
  logic [31:0] cfg_data, rom_data;
  logic [47:0] exp_cfg [$];
  logic [31:0] exp_rom [$];
  int n_mismatch = 0;
  int check_count = 0;
  int lc = 0;
  int gap = 0;

  always #50 i_clk = ~i_clk;
  initial begin
    #37;
    forever #80 i_link_clk = ~i_link_clk;
  end

  seec_top seec_top_inst (
    .i_clk(i_clk), .i_rst(i_rst),
    .i_fundamental_reset_n(i_fundamental_reset_n),
    .i_link_clk(i_link_clk),
    .o_mem_serial_clock(sck), .o_mem_select_n(cs_n),
    .o_mem_serial_in(si), .i_mem_serial_out_pin(so),
    .o_cfg_we(cfg_we), .o_cfg_index(cfg_index), .o_cfg_data(cfg_data),
    .o_load_done(load_done), .o_load_err(load_err),
    .i_rom_req(i_rom_req), .i_rom_addr(i_rom_addr),
    .o_rom_busy(rom_busy), .o_rom_valid(rom_valid), .o_rom_data(rom_data)
  );
  seec_mem_model seec_mem_model_inst (
    .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .o_so(so)
  );

  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cfg(input logic [47:0] e, input logic [47:0] g);
    chk("cfg", e, g);
  endtask

  task automatic chk_rom(input logic [31:0] e, input logic [31:0] g);
    chk("rom", 48'(e), 48'(g));
  endtask

  task wrap_up;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // result monitor: oldest note against each pulse
  // ****************************************
  // falling edge: clear of the edge that launches the pulse
  always @(negedge i_clk) begin
    if (cfg_we === 1'b1) begin
      if (exp_cfg.size() == 0) chk("cfg extra", 48'h0, 48'h1);
      else chk_cfg(exp_cfg.pop_front(), {cfg_index, cfg_data});
    end
    if (rom_valid === 1'b1) begin
      if (exp_rom.size() == 0) chk("rom extra", 48'h0, 48'h1);
      else chk_rom(exp_rom.pop_front(), rom_data);
    end
  end

  // ****************************************
  // wire watcher on the link clock
  // ****************************************
  // pins settle after the rising edge, so look at the falling one
  always @(negedge i_link_clk) begin
    lc++;
    if (cs_n === 1'b1) begin
      chk("sck idle", 48'h0, 48'(sck));
      gap++;
      have = 1'b0;
    end else begin
      if (gap > 0) chk("deselect gap", 48'h1, 48'(gap >= 4));
      gap = 0;
      if (sck === 1'b1 && sck_prev === 1'b0) begin
        if (have) chk("sck period", 48'h4, 48'(lc));
        have = 1'b1;
        lc = 0;
      end
    end
    sck_prev = sck;
  end

  task automatic image(input logic [15:0] n, input int recs);
    logic [47:0] r;
    seec_mem_model_inst.mem[0] = n[15:8];
    seec_mem_model_inst.mem[1] = n[7:0];
    for (int i = 0; i < recs; i++) begin
      r = {16'($urandom), 32'($urandom)};
      for (int b = 0; b < 6; b++) begin
        seec_mem_model_inst.mem[2 + 6 * i + b] = r[47 - 8 * b -: 8];
      end
      exp_cfg.push_back(r);
    end
  endtask

  task automatic wait_done(input logic e_err);
    int k;
    k = 0;
    while (load_done !== 1'b1 && k < 20000) begin
      @(negedge i_clk);
      k++;
    end
    // let the monitor take the last record note first
    @(negedge i_clk);
    chk("load done", 48'h1, 48'(load_done));
    chk("load err", 48'(e_err), 48'(load_err));
    chk("cfg left", 48'h0, 48'(exp_cfg.size()));
  endtask

  task automatic rom_rd(input logic [14:0] a, input bit poke);
    logic [15:0] m;
    int k;
    m = {1'b1, a};
    exp_rom.push_back({seec_mem_model_inst.mem[m],
      seec_mem_model_inst.mem[m + 16'h0001],
      seec_mem_model_inst.mem[m + 16'h0002],
      seec_mem_model_inst.mem[m + 16'h0003]});
    @(negedge i_clk);
    i_rom_req = 1'b1;
    i_rom_addr = a;
    @(negedge i_clk);
    i_rom_req = 1'b0;
    if (poke) begin
      // a request while busy is dropped without a trace
      repeat (20) @(negedge i_clk);
      chk("rom busy", 48'h1, 48'(rom_busy));
      i_rom_req = 1'b1;
      i_rom_addr = ~a;
      @(negedge i_clk);
      i_rom_req = 1'b0;
    end
    k = 0;
    while (rom_valid !== 1'b1 && k < 3000) begin
      @(negedge i_clk);
      k++;
    end
    chk("rom valid", 48'h1, 48'(rom_valid));
  endtask

  initial begin
    repeat (40000) @(posedge i_clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    logic [15:0] hdr [3];
    logic er [3];
    hdr = '{16'h0000, 16'hFFFF, 16'h1556};
    er = '{1'b0, 1'b0, 1'b1};
    void'($urandom(32'h8436_9259));
    for (int a = 0; a < 65536; a++) begin
      seec_mem_model_inst.mem[a] = 8'($urandom);
    end
    image(16'h0003, 3);
    repeat (10) @(negedge i_clk);
    chk("busy in reset", 48'h1, 48'(rom_busy));
    i_rst = 1'b0;
    wait_done(1'b0);
    rom_rd(15'h0000, 1'b0);
    rom_rd(15'h7FFE, 1'b1);
    rom_rd(15'h7FFF, 1'b0);
    for (int i = 0; i < 3; i++) rom_rd(15'($urandom), 1'b0);
    @(negedge i_clk);
    chk("rom left", 48'h0, 48'(exp_rom.size()));
    // ****************************************
    // fundamental reset with refused headers
    // ****************************************
    for (int t = 0; t < 3; t++) begin
      image(hdr[t], 0);
      @(negedge i_clk);
      i_fundamental_reset_n = 1'b0;
      repeat (5) @(negedge i_clk);
      chk("done in reset", 48'h0, 48'(load_done));
      i_fundamental_reset_n = 1'b1;
      wait_done(er[t]);
    end
    image(16'h0001, 1);
    @(negedge i_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    wait_done(1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
